// ===== pkg/bsd_defines.svh
// Purpose: constants of the splice anomaly histogram detector
// Assumes: included by bare name
// Notes: counts in mclk cycles where timing applies
`ifndef BSD_DEFINES_SVH
`define BSD_DEFINES_SVH

// ----------------------------------------------------------------
// detection
// ----------------------------------------------------------------
`define BSD_THRESHOLD        8
`define BSD_CNT_RST          8'h00
`define BSD_CODE_NTF         8'hFE
`define BSD_CODE_LOS         8'hFF

// ----------------------------------------------------------------
// history and automatic clear
// ----------------------------------------------------------------
`define BSD_HIST_DAYS        14
`define BSD_AUTO_RESET_DAYS  14
`define BSD_NVM_PTR_ADDR     4'hE
`define BSD_NVM_LAST_ADDR    4'hE

// ----------------------------------------------------------------
// data-mode periodic run, in mclk cycles
// ----------------------------------------------------------------
`define BSD_RUN_PERIOD       1000
`define BSD_RUN_WINDOW       250

// ----------------------------------------------------------------
// monitoring read selectors
// ----------------------------------------------------------------
`define BSD_FDL_HIST         2'h0
`define BSD_FDL_RESULT       2'h1
`define BSD_FDL_HISTORY      2'h2

`endif

// ===== pkg/bsd_pkg.sv
// Purpose: types of the splice anomaly histogram detector
// Assumes: nothing
// Notes: constants live in bsd_defines.svh
package bsd_pkg;

  // ----------------------------------------------------------------
  // nonvolatile store sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESTORE_REQ,
    ST_RESTORE_WAIT,
    ST_IDLE,
    ST_SAVE_PTR
  } bsd_nvm_state_e;

  typedef logic [7:0] bsd_code_t;

endpackage

// ===== pkg/bsd_hist_if.sv
// Purpose: carrier between detector control and histogram store
// Assumes: one clock, mclk
// Notes: counts are exposed whole for scan and read
`timescale 1ns/10ps
interface bsd_hist_if #(
  parameter int NPOINT = 16,
  parameter int NBIN   = 18,
  parameter int CNT_W  = 8
);
  localparam int PW = $clog2(NPOINT);
  localparam int BW = $clog2(NBIN);

  logic             ce;
  logic             inc;
  logic [PW-1:0]    inc_point;
  logic [BW-1:0]    inc_bin;
  logic             clear;
  logic [CNT_W-1:0] cnt     [NPOINT][NBIN];
  logic [CNT_W-1:0] max_cnt [NPOINT];
  logic [BW-1:0]    max_bin [NPOINT];

  modport ctl   (output ce, inc, inc_point, inc_bin, clear,
                 input  cnt, max_cnt, max_bin);
  modport store (input  ce, inc, inc_point, inc_bin, clear,
                 output cnt, max_cnt, max_bin);
endinterface

// ===== hw/bsd_hist.sv
// Purpose: saturating histogram counters per receiver point and distance bin
// Assumes: clear and inc come from the same clock domain
// Notes: worst bin is the highest count, lowest bin on ties
`timescale 1ns/10ps
`include "bsd_defines.svh"
module bsd_hist #(
  parameter int NPOINT = 16,
  parameter int NBIN   = 18,
  parameter int CNT_W  = 8
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  bsd_hist_if.store hif
);
  localparam int BW = $clog2(NBIN);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPOINT; p++)
  begin : g_pt
    for (genvar b = 0; b < NBIN; b++)
    begin : g_bin
      wire hit = hif.inc && (hif.inc_point == p) && (hif.inc_bin == b);
      wire sat = (hif.cnt[p][b] == CNT_MAX);
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
          hif.cnt[p][b] <= CNT_W'(`BSD_CNT_RST);
        else if (hif.ce)
        begin
          if (hif.clear)
            hif.cnt[p][b] <= CNT_W'(`BSD_CNT_RST);
          else if (hit && !sat)
            hif.cnt[p][b] <= hif.cnt[p][b] + CNT_W'(1);
        end
      end
    end

    // ----------------------------------------------------------------
    // worst bin of this point
    // ----------------------------------------------------------------
    always_comb
    begin
      hif.max_cnt[p] = hif.cnt[p][0];
      hif.max_bin[p] = '0;
      for (int b = 1; b < NBIN; b++)
      begin
        if (hif.cnt[p][b] > hif.max_cnt[p])
        begin
          hif.max_cnt[p] = hif.cnt[p][b];
          hif.max_bin[p] = BW'(b);
        end
      end
    end
  end
endmodule

// ===== hw/bsd_top.sv
// Purpose: splice anomaly histogram detector of a loop line unit
// Assumes: all inputs come from logic on mclk; nvm answers one read at a time
// Notes: results are bin indices, or the no-trouble or loss-of-signal code
//
// Contract
// - each flagged impedance change increments the counter of its distance bin
// - count in training, and periodically in data mode once synchronized
// - report a bin only above eight; otherwise active unit reports no-trouble
// - undetected remote unit gives the loss-of-signal code
// - several bins over threshold: report the one with the highest count
// - save current results to nonvolatile memory at each daily save
// - keep fourteen daily results and read them back after power-up
// - power-up clears counters and buffers, stored history kept
// - manual reset acts only after affirmative confirmation, then counting resumes
// - manual reset clears locally and sends reset over the operations channel
// - each unit sends its counts and bins over the operations channel
// - detector resets itself every fourteen days
// - every detector reset adds a reset event-log entry
// - bad-splice log entry only for first detection since last reset
// - all results and histogram counts readable over the facility data link
// - results view steps backward through the last fourteen days
`timescale 1ns/10ps
`include "bsd_defines.svh"
module bsd_top #(
  parameter int NPOINT     = 16,
  parameter int NBIN       = 18,
  parameter int CNT_W      = 8,
  parameter int RUN_PERIOD = `BSD_RUN_PERIOD,
  parameter int RUN_WINDOW = `BSD_RUN_WINDOW,
  localparam int PW        = $clog2(NPOINT),
  localparam int BW        = $clog2(NBIN),
  localparam int RW        = NPOINT * 8
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire logic              evt_valid,
  input  wire logic [PW-1:0]     evt_point,
  input  wire logic [BW-1:0]     evt_bin,
  input  wire logic              loop_training,
  input  wire logic              loop_sync,
  input  wire logic [NPOINT-1:0] remote_present,
  input  wire logic              day_save_tick,
  input  wire logic              man_reset_req,
  input  wire logic              confirm_valid,
  input  wire logic              confirm_yes,
  output logic                   confirm_pending,
  input  wire logic              eoc_rx_reset,
  output logic                   eoc_tx_reset,
  input  wire logic              eoc_tx_ready,
  output logic                   eoc_tx_valid,
  output logic [PW-1:0]          eoc_tx_point,
  output logic [BW-1:0]          eoc_tx_bin,
  output logic [CNT_W-1:0]       eoc_tx_count,
  input  wire logic              fdl_rd_req,
  input  wire logic [1:0]        fdl_rd_sel,
  input  wire logic [3:0]        fdl_rd_day,
  input  wire logic [PW-1:0]     fdl_rd_point,
  input  wire logic [BW-1:0]     fdl_rd_bin,
  output logic                   fdl_rd_ack,
  output logic [7:0]             fdl_rd_data,
  output logic                   nvm_wr_en,
  output logic                   nvm_rd_req,
  output logic [3:0]             nvm_addr,
  output logic [RW-1:0]          nvm_wr_data,
  input  wire logic              nvm_rd_valid,
  input  wire logic [RW-1:0]     nvm_rd_data,
  output logic                   restore_done,
  input  wire logic              view_back,
  input  wire logic              view_home,
  output logic [3:0]             view_age,
  output logic [RW-1:0]          view_results,
  output logic [RW-1:0]          result,
  output logic                   evlog_reset,
  output logic                   evlog_splice
);
  localparam int RCW = $clog2(RUN_PERIOD);
  localparam logic [3:0] DAYS_LAST = 4'(`BSD_HIST_DAYS - 1);
  localparam logic [3:0] AUTO_LAST = 4'(`BSD_AUTO_RESET_DAYS - 1);

  bsd_hist_if #(.NPOINT(NPOINT), .NBIN(NBIN), .CNT_W(CNT_W)) hif ();

  bsd_hist #(.NPOINT(NPOINT), .NBIN(NBIN), .CNT_W(CNT_W)) u_hist (
    .mclk   (mclk),
    .arst_n (arst_n),
    .hif    (hif)
  );

  bsd_pkg::bsd_nvm_state_e state;
  logic [RW-1:0]    mem [`BSD_HIST_DAYS];
  logic [3:0]       wr_ptr;
  logic [3:0]       rst_idx;
  logic [3:0]       day_cnt;
  logic [RCW-1:0]   run_cnt;
  logic             detected;
  logic [PW-1:0]    sc_point;
  logic [BW-1:0]    sc_bin;
  logic [NPOINT-1:0] over;
  logic [RW-1:0]    next_result;

  // ----------------------------------------------------------------
  // run gating and detector clears
  // ----------------------------------------------------------------
  wire run_open   = loop_training || (loop_sync && (run_cnt < RCW'(RUN_WINDOW)));
  wire man_hit    = confirm_pending && confirm_valid && confirm_yes;
  wire auto_hit   = day_save_tick && (day_cnt == AUTO_LAST);
  wire det_clear  = man_hit || eoc_rx_reset || auto_hit;
  wire any_over   = |over;
  wire run_wrap   = (run_cnt == RCW'(RUN_PERIOD - 1));

  assign hif.ce        = clk_en;
  assign hif.clear     = det_clear;
  assign hif.inc       = evt_valid && run_open && !det_clear;
  assign hif.inc_point = evt_point;
  assign hif.inc_bin   = evt_bin;

  // ----------------------------------------------------------------
  // per-point result decision
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPOINT; p++)
  begin : g_res
    assign over[p] = remote_present[p] && (hif.max_cnt[p] > CNT_W'(`BSD_THRESHOLD));
    assign next_result[p*8 +: 8] =
      !remote_present[p] ? `BSD_CODE_LOS :
      over[p]            ? 8'(hif.max_bin[p]) :
                           `BSD_CODE_NTF;
  end

  // ----------------------------------------------------------------
  // history slot addressing
  // ----------------------------------------------------------------
  wire [4:0] view_sum  = 5'(wr_ptr) + 5'(DAYS_LAST) - 5'(view_age);
  wire [3:0] view_slot = (view_sum > 5'(DAYS_LAST)) ? 4'(view_sum - 5'(`BSD_HIST_DAYS))
                                                    : view_sum[3:0];
  wire [4:0] fdl_sum   = 5'(wr_ptr) + 5'(DAYS_LAST) - 5'(fdl_rd_day);
  wire [3:0] fdl_slot  = (fdl_sum > 5'(DAYS_LAST)) ? 4'(fdl_sum - 5'(`BSD_HIST_DAYS))
                                                   : fdl_sum[3:0];
  wire [3:0] ptr_inc   = (wr_ptr == DAYS_LAST) ? 4'h0 : 4'(wr_ptr + 4'h1);
  wire [3:0] rd_ptr    = (nvm_rd_data[3:0] > DAYS_LAST) ? 4'h0 : nvm_rd_data[3:0];
  wire       rd_last   = (rst_idx == `BSD_NVM_LAST_ADDR);

  // ----------------------------------------------------------------
  // monitoring read mux
  // ----------------------------------------------------------------
  wire [RW-1:0] fdl_hist_word = mem[fdl_slot];
  wire [7:0] fdl_mux =
    (fdl_rd_sel == `BSD_FDL_HIST)    ? 8'(hif.cnt[fdl_rd_point][fdl_rd_bin]) :
    (fdl_rd_sel == `BSD_FDL_RESULT)  ? result[fdl_rd_point*8 +: 8] :
    (fdl_rd_sel == `BSD_FDL_HISTORY) ? fdl_hist_word[fdl_rd_point*8 +: 8] :
                                       8'h00;

  // ----------------------------------------------------------------
  // scan pointers for the operations channel
  // ----------------------------------------------------------------
  wire       sc_take   = !eoc_tx_valid || eoc_tx_ready;
  wire       sc_blast  = (sc_bin == BW'(NBIN - 1));
  wire       sc_plast  = (sc_point == PW'(NPOINT - 1));

  // ----------------------------------------------------------------
  // results, confirmation and event log
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result          <= {NPOINT{`BSD_CODE_NTF}};
      confirm_pending <= 1'b0;
      eoc_tx_reset    <= 1'b0;
      evlog_reset     <= 1'b0;
      evlog_splice    <= 1'b0;
      detected        <= 1'b0;
    end
    else if (clk_en)
    begin
      result          <= next_result;
      eoc_tx_reset    <= man_hit;
      evlog_reset     <= det_clear;
      evlog_splice    <= any_over && !detected && !det_clear;
      if (man_reset_req)
        confirm_pending <= 1'b1;
      else if (confirm_valid)
        confirm_pending <= 1'b0;
      if (det_clear)
        detected <= 1'b0;
      else if (any_over)
        detected <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // run period and fourteen-day counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_cnt <= '0;
      day_cnt <= 4'h0;
    end
    else if (clk_en)
    begin
      run_cnt <= (run_wrap || !loop_sync) ? '0 : RCW'(run_cnt + 1'b1);
      if (det_clear)
        day_cnt <= 4'h0;
      else if (day_save_tick)
        day_cnt <= 4'(day_cnt + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // histogram scan out over the operations channel
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      eoc_tx_valid <= 1'b0;
      eoc_tx_point <= '0;
      eoc_tx_bin   <= '0;
      eoc_tx_count <= '0;
      sc_point     <= '0;
      sc_bin       <= '0;
    end
    else if (clk_en && sc_take)
    begin
      eoc_tx_valid <= 1'b1;
      eoc_tx_point <= sc_point;
      eoc_tx_bin   <= sc_bin;
      eoc_tx_count <= hif.cnt[sc_point][sc_bin];
      sc_bin       <= sc_blast ? '0 : BW'(sc_bin + 1'b1);
      if (sc_blast)
        sc_point <= sc_plast ? '0 : PW'(sc_point + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // monitoring read port and history view
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fdl_rd_ack   <= 1'b0;
      fdl_rd_data  <= 8'h00;
      view_age     <= 4'h0;
      view_results <= '0;
    end
    else if (clk_en)
    begin
      fdl_rd_ack   <= fdl_rd_req;
      if (fdl_rd_req)
        fdl_rd_data <= fdl_mux;
      view_results <= mem[view_slot];
      if (view_home)
        view_age <= 4'h0;
      else if (view_back && (view_age != DAYS_LAST))
        view_age <= 4'(view_age + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile restore and daily save
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state        <= bsd_pkg::ST_RESTORE_REQ;
      nvm_wr_en    <= 1'b0;
      nvm_rd_req   <= 1'b0;
      nvm_addr     <= 4'h0;
      nvm_wr_data  <= '0;
      rst_idx      <= 4'h0;
      wr_ptr       <= 4'h0;
      restore_done <= 1'b0;
    end
    else if (clk_en)
    begin
      nvm_wr_en  <= 1'b0;
      nvm_rd_req <= 1'b0;
      case (state)
        bsd_pkg::ST_RESTORE_REQ:
        begin
          nvm_rd_req <= 1'b1;
          nvm_addr   <= rst_idx;
          state      <= bsd_pkg::ST_RESTORE_WAIT;
        end
        bsd_pkg::ST_RESTORE_WAIT:
        begin
          if (nvm_rd_valid)
          begin
            if (rd_last)
            begin
              wr_ptr       <= rd_ptr;
              restore_done <= 1'b1;
              state        <= bsd_pkg::ST_IDLE;
            end
            else
            begin
              rst_idx <= 4'(rst_idx + 4'h1);
              state   <= bsd_pkg::ST_RESTORE_REQ;
            end
          end
        end
        bsd_pkg::ST_IDLE:
        begin
          if (day_save_tick)
          begin
            nvm_wr_en   <= 1'b1;
            nvm_addr    <= wr_ptr;
            nvm_wr_data <= result;
            wr_ptr      <= ptr_inc;
            state       <= bsd_pkg::ST_SAVE_PTR;
          end
        end
        bsd_pkg::ST_SAVE_PTR:
        begin
          nvm_wr_en   <= 1'b1;
          nvm_addr    <= `BSD_NVM_PTR_ADDR;
          nvm_wr_data <= RW'(wr_ptr);
          state       <= bsd_pkg::ST_IDLE;
        end
        default:
          state <= bsd_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // history memory
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (clk_en)
    begin
      if (state == bsd_pkg::ST_RESTORE_WAIT && nvm_rd_valid && !rd_last)
        mem[rst_idx] <= nvm_rd_data;
      else if (state == bsd_pkg::ST_IDLE && day_save_tick)
        mem[wr_ptr] <= result;
    end
  end
endmodule

// ===== sim/bsd_chk.sv
// Purpose: port assertions of the splice detector
// Assumes: one clock domain, mclk
// Notes: bound into bsd_top
`timescale 1ns/10ps
module bsd_chk #(
  parameter int NPOINT = 16,
  parameter int NBIN   = 18,
  parameter int CNT_W  = 8,
  localparam int PW    = $clog2(NPOINT),
  localparam int BW    = $clog2(NBIN),
  localparam int RW    = NPOINT * 8
) (
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire logic              clk_en,
  input wire logic              man_reset_req,
  input wire logic              confirm_valid,
  input wire logic              confirm_yes,
  input wire logic              confirm_pending,
  input wire logic              eoc_rx_reset,
  input wire logic              eoc_tx_reset,
  input wire logic              eoc_tx_ready,
  input wire logic              eoc_tx_valid,
  input wire logic [PW-1:0]     eoc_tx_point,
  input wire logic [BW-1:0]     eoc_tx_bin,
  input wire logic [CNT_W-1:0]  eoc_tx_count,
  input wire logic              fdl_rd_req,
  input wire logic              fdl_rd_ack,
  input wire logic              nvm_wr_en,
  input wire logic [3:0]        nvm_addr,
  input wire logic [NPOINT-1:0] remote_present,
  input wire logic [RW-1:0]     result,
  input wire logic              evlog_reset
);
  // ----------------------------------------------------------------
  // helpers and assertions
  // ----------------------------------------------------------------
  wire answer_t = clk_en && confirm_pending && confirm_valid && !man_reset_req;
  wire los_t    = clk_en && !remote_present[3];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  ask_open_a: assert property (clk_en && man_reset_req |=> confirm_pending)
    else $error("no pending confirmation");
  confirm_yes_a: assert property (answer_t && confirm_yes |=>
    eoc_tx_reset && evlog_reset && !confirm_pending)
    else $error("confirmed reset not carried out");
  confirm_no_a: assert property (answer_t && !confirm_yes |=>
    !eoc_tx_reset && !confirm_pending)
    else $error("declined reset acted upon");
  tx_reset_cause_a: assert property (eoc_tx_reset |-> $past(answer_t) && $past(confirm_yes))
    else $error("unconfirmed channel reset");
  rx_reset_log_a: assert property (clk_en && eoc_rx_reset |=> evlog_reset)
    else $error("received reset not logged");
  los_code_a: assert property ($past(los_t) && $past(arst_n) |-> result[31:24] == 8'hFF)
    else $error("loss code missing");
  fdl_answer_a: assert property (clk_en && fdl_rd_req |-> ##[1:2] fdl_rd_ack)
    else $error("monitor read not answered");
  stream_hold_a: assert property (clk_en && eoc_tx_valid && !eoc_tx_ready |=>
    eoc_tx_valid && $stable(eoc_tx_point) && $stable(eoc_tx_bin) && $stable(eoc_tx_count))
    else $error("stream word changed while stalled");
  save_ptr_a: assert property (nvm_wr_en && nvm_addr != 4'hE |=>
    nvm_wr_en && nvm_addr == 4'hE)
    else $error("daily save without pointer write");

  cov_yes_c: cover property (answer_t && confirm_yes);
  cov_save_c: cover property (nvm_wr_en && nvm_addr != 4'hE);
  cov_stall_c: cover property (eoc_tx_valid && !eoc_tx_ready);
endmodule

bind bsd_top bsd_chk #(.NPOINT(NPOINT), .NBIN(NBIN), .CNT_W(CNT_W)) chk (.*);

// ===== sim/bsd_far_model.sv
// Purpose: nonvolatile store and channel receiver beside the detector
// Assumes: one read outstanding at a time
// Notes: read data shows inverse when not valid
`timescale 1ns/10ps
module bsd_far_model (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         nvm_rd_req,
  input  wire logic         nvm_wr_en,
  input  wire logic [3:0]   nvm_addr,
  input  wire logic [127:0] nvm_wr_data,
  output logic              nvm_rd_valid,
  output logic [127:0]      nvm_rd_data,
  output logic              eoc_tx_ready
);
  logic [127:0] mem [15];
  logic [3:0]   raddr;
  logic [2:0]   pipe;
  logic [1:0]   rdy_cnt;

  // store kept across resets; reads answer after a delay
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pipe         <= 3'h0;
      nvm_rd_valid <= 1'b0;
      rdy_cnt      <= 2'd0;
    end
    else
    begin
      rdy_cnt      <= rdy_cnt + 2'd1;
      pipe         <= {pipe[1:0], nvm_rd_req};
      nvm_rd_valid <= pipe[2];
      if (nvm_wr_en)
        mem[nvm_addr] <= nvm_wr_data;
      if (nvm_rd_req)
        raddr <= nvm_addr;
    end
  end
  assign nvm_rd_data  = nvm_rd_valid ? mem[raddr] : ~mem[raddr];
  assign eoc_tx_ready = rdy_cnt != 2'd3;
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench of the splice detector
// Assumes: inputs driven at falling edge
// Notes: short run window parameters
`timescale 1ns/10ps
module tb;
  logic mclk, arst_n, clk_en, evt_valid, loop_training, loop_sync, day_save_tick;
  logic man_reset_req, confirm_valid, confirm_yes, eoc_rx_reset, fdl_rd_req;
  logic view_back, view_home, nvm_rd_valid, eoc_tx_ready, confirm_pending;
  logic eoc_tx_reset, eoc_tx_valid, fdl_rd_ack, nvm_wr_en, nvm_rd_req;
  logic restore_done, evlog_reset, evlog_splice;
  logic [3:0] evt_point, fdl_rd_day, fdl_rd_point, eoc_tx_point, nvm_addr, view_age;
  logic [4:0] evt_bin, fdl_rd_bin, eoc_tx_bin;
  logic [1:0] fdl_rd_sel;
  logic [15:0] remote_present;
  logic [7:0] eoc_tx_count, fdl_rd_data, rv;
  logic [127:0] nvm_rd_data, nvm_wr_data, view_results, result, exp_w;
  int err_total = 0, compares = 0, n_rst = 0, n_spl = 0, n_tx = 0, n0;

  bsd_top #(.RUN_PERIOD(8), .RUN_WINDOW(2)) dut (.mclk, .arst_n, .clk_en,
    .evt_valid, .evt_point, .evt_bin, .loop_training, .loop_sync, .remote_present,
    .day_save_tick, .man_reset_req, .confirm_valid, .confirm_yes, .confirm_pending,
    .eoc_rx_reset, .eoc_tx_reset, .eoc_tx_ready, .eoc_tx_valid, .eoc_tx_point,
    .eoc_tx_bin, .eoc_tx_count, .fdl_rd_req, .fdl_rd_sel, .fdl_rd_day, .fdl_rd_point,
    .fdl_rd_bin, .fdl_rd_ack, .fdl_rd_data, .nvm_wr_en, .nvm_rd_req, .nvm_addr,
    .nvm_wr_data, .nvm_rd_valid, .nvm_rd_data, .restore_done, .view_back, .view_home,
    .view_age, .view_results, .result, .evlog_reset, .evlog_splice);
  bsd_far_model far (.mclk, .arst_n, .nvm_rd_req, .nvm_wr_en, .nvm_addr, .nvm_wr_data,
    .nvm_rd_valid, .nvm_rd_data, .eoc_tx_ready);

  // ----------------------------------------------------------------
  // clock, pulse counters, tasks
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    n_rst += (evlog_reset === 1'b1);
    n_spl += (evlog_splice === 1'b1);
    n_tx  += (eoc_tx_reset === 1'b1);
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic ev(input logic [3:0] p, input logic [4:0] b, input int n);
    evt_point = p;
    evt_bin   = b;
    evt_valid = 1'b1;
    repeat (n) @(negedge mclk);
    evt_valid = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic rd(input logic [1:0] s, input logic [3:0] p, input logic [4:0] b);
    fdl_rd_sel   = s;
    fdl_rd_point = p;
    fdl_rd_bin   = b;
    fdl_rd_req   = 1'b1;
    @(negedge mclk);
    fdl_rd_req = 1'b0;
    for (int i = 0; i < 3 && fdl_rd_ack !== 1'b1; i++) @(negedge mclk);
    rv = fdl_rd_data;
    @(negedge mclk);
  endtask
  task conclude;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_restore;
    for (int i = 0; i < 300 && restore_done !== 1'b1; i++) @(negedge mclk);
    chk(restore_done, 1, "history not restored");
    rd(2'h2, 4'h0, 5'h0);
    chk(rv, 8'h12, "newest stored result");
    rd(2'h0, 4'h1, 5'h5);
    chk(rv, 8'h00, "counter after power-up");
  endtask
  task t_count;
    ev(4'h1, 5'h5, 8);
    rd(2'h0, 4'h1, 5'h5);
    chk(rv, 8'h08, "bin count");
    chk(result[15:8], 8'hFE, "at threshold");
    ev(4'h1, 5'h5, 1);
    chk(result[15:8], 8'h05, "over threshold");
    chk(n_spl, 1, "first detection entry");
    ev(4'h1, 5'h7, 10);
    chk(result[15:8], 8'h07, "worst bin");
    rd(2'h1, 4'h1, 5'h0);
    chk(rv, 8'h07, "result over link");
    chk(n_spl, 1, "repeat detection entry");
    ev(4'h2, 5'h2, 260);
    rd(2'h0, 4'h2, 5'h2);
    chk(rv, 8'hFF, "saturated count");
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge mclk);
      if (eoc_tx_valid && eoc_tx_ready && eoc_tx_point == 4'h1 && eoc_tx_bin == 5'h5)
        break;
    end
    chk(eoc_tx_count, 8'h09, "streamed count");
    @(negedge mclk);
  endtask
  task t_mode;
    loop_training = 1'b0;
    ev(4'h6, 5'h3, 4);
    rd(2'h0, 4'h6, 5'h3);
    chk(rv, 8'h00, "count while unsynced");
    loop_sync = 1'b1;
    ev(4'h6, 5'h3, 8);
    rd(2'h0, 4'h6, 5'h3);
    chk(rv, 8'h02, "count in run window");
    loop_training = 1'b1;
    clk_en = 1'b0;
    remote_present[3] = 1'b0;
    repeat (3) @(negedge mclk);
    chk(result[31:24], 8'hFE, "held while disabled");
    clk_en = 1'b1;
    repeat (3) @(negedge mclk);
    chk(result[31:24], 8'hFF, "loss code");
    remote_present[3] = 1'b1;
  endtask
  task t_manual;
    n0 = n_rst;
    pulse(man_reset_req);
    chk(confirm_pending, 1, "pending");
    pulse(confirm_valid);
    rd(2'h0, 4'h1, 5'h5);
    chk(rv, 8'h09, "declined keeps counts");
    chk(n_tx, 0, "declined sends nothing");
    pulse(man_reset_req);
    confirm_yes = 1'b1;
    pulse(confirm_valid);
    rd(2'h0, 4'h1, 5'h5);
    chk(rv, 8'h00, "confirmed clears");
    chk(n_tx, 1, "channel reset sent");
    chk(n_rst, n0 + 1, "reset entry");
    ev(4'h1, 5'h5, 9);
    chk(result[15:8], 8'h05, "counting resumed");
    chk(n_spl, 2, "entry after reset");
    pulse(eoc_rx_reset);
    rd(2'h0, 4'h1, 5'h5);
    chk(rv, 8'h00, "remote reset clears");
    chk(n_tx, 1, "no echo of remote reset");
    chk(n_rst, n0 + 2, "remote reset entry");
  endtask
  task t_days;
    ev(4'h4, 5'h6, 9);
    exp_w = {16{8'hFE}};
    exp_w[39:32] = 8'h06;
    pulse(day_save_tick);
    chk(far.mem[3], exp_w, "daily save");
    chk(far.mem[14][3:0], 4'h4, "save pointer");
    pulse(view_home);
    chk(view_results, exp_w, "view newest");
    pulse(view_back);
    chk(view_age, 4'h1, "view age");
    chk(view_results, {16{8'h12}}, "view older");
    n0 = n_rst;
    repeat (12) pulse(day_save_tick);
    rd(2'h0, 4'h4, 5'h6);
    chk(rv, 8'h09, "kept before day 14");
    pulse(day_save_tick);
    rd(2'h0, 4'h4, 5'h6);
    chk(rv, 8'h00, "auto clear");
    chk(n_rst, n0 + 1, "auto reset entry");
  endtask

  initial
  begin
    {arst_n, evt_valid, loop_sync, day_save_tick, man_reset_req, confirm_valid} = '0;
    {confirm_yes, eoc_rx_reset, fdl_rd_req, view_back, view_home} = '0;
    {evt_point, evt_bin, fdl_rd_sel, fdl_rd_day, fdl_rd_point, fdl_rd_bin} = '0;
    loop_training  = 1'b1;
    clk_en         = 1'b1;
    remote_present = 16'hFFFF;
    for (int i = 0; i < 14; i++) far.mem[i] = {16{8'(i + 16)}};
    far.mem[14] = 128'h3;
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    t_restore;
    t_count;
    t_mode;
    t_manual;
    t_days;
    conclude;
  end
  initial
  begin
    #200_000;
    err_total++;
    conclude;
  end
endmodule
